// ==== pkg/rx_msg_pkg.sv ====
// Constants and types for the receive message indication port
package rx_msg_pkg;
	localparam int KIND_W     = 5;
	localparam int BYTE_W     = 8;
	localparam int MAX_BYTES  = 8;
	localparam int CNT_W      = 4;
	localparam int FIFO_DEPTH = 4;

	// Kind codes
	localparam logic [KIND_W-1:0] KIND_ERR_COR    = 5'h00;
	localparam logic [KIND_W-1:0] KIND_ERR_FATAL  = 5'h02;
	localparam logic [KIND_W-1:0] KIND_INT_FIRST  = 5'h03;
	localparam logic [KIND_W-1:0] KIND_PM_NAK     = 5'h0E;
	localparam logic [KIND_W-1:0] KIND_SLOT_PWR   = 5'h0F;
	localparam logic [KIND_W-1:0] KIND_LTR        = 5'h10;
	localparam logic [KIND_W-1:0] KIND_OBFF       = 5'h11;
	localparam logic [KIND_W-1:0] KIND_UNLOCK     = 5'h12;
	localparam logic [KIND_W-1:0] KIND_VDM0       = 5'h13;
	localparam logic [KIND_W-1:0] KIND_VDM1       = 5'h14;
	localparam logic [KIND_W-1:0] KIND_ATS_FIRST  = 5'h15;
	localparam logic [KIND_W-1:0] KIND_ATS_LAST   = 5'h18;

	// Strobe lengths in cycles
	localparam logic [CNT_W-1:0] LEN_SHORT    = 4'h2;
	localparam logic [CNT_W-1:0] LEN_OBFF     = 4'h3;
	localparam logic [CNT_W-1:0] LEN_VDM_NODATA = 4'h4;
	localparam logic [CNT_W-1:0] LEN_SIX      = 4'h6;
	localparam logic [CNT_W-1:0] LEN_VDM_DATA = 4'h8;
	localparam logic [CNT_W-1:0] LEN_NONE     = 4'h0;

	// Message record held in the FIFO: kind, length, eight bytes in order
	localparam int REC_W = KIND_W + CNT_W + MAX_BYTES * BYTE_W;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} send_state_t;
endpackage : rx_msg_pkg

// ==== verilog/msg_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module msg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             clkEn,
	// Fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
			$error("msg_fifo DEPTH must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW:0]      wrPtr_ff;
	logic [AW:0]      rdPtr_ff;
	logic [WIDTH-1:0] outData_ff;
	logic             outValid_ff;

	wire logic isFull  = (wrPtr_ff[AW] != rdPtr_ff[AW]) && (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
	wire logic isEmpty = (wrPtr_ff == rdPtr_ff);
	wire logic doWr    = inValid && !isFull;
	// Output register refills when empty or being drained
	wire logic doRd    = !isEmpty && (!outValid_ff || outReady);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_ff    <= '0;
			rdPtr_ff    <= '0;
			outValid_ff <= 1'b0;
			outData_ff  <= '0;
		end else if (clkEn) begin
			if (doWr) begin
				mem_ff[wrPtr_ff[AW-1:0]] <= inData;
				wrPtr_ff                 <= wrPtr_ff + 1'b1;
			end
			if (doRd) begin
				outData_ff <= mem_ff[rdPtr_ff[AW-1:0]];
				rdPtr_ff   <= rdPtr_ff + 1'b1;
				outValid_ff <= 1'b1;
			end else if (outReady) begin
				outValid_ff <= 1'b0;
			end
		end
	end

	assign inReady  = !isFull;
	assign outValid = outValid_ff;
	assign outData  = outData_ff;
endmodule : msg_fifo

// ==== verilog/rx_msg_indication_port.sv ====
// Receive message indication port: queues decoded messages and serialises them
`timescale 1ns/1ps
module rx_msg_indication_port
	import rx_msg_pkg::*;
#(
	parameter bit rx_msg_port_enable_param = 1'b1,
	parameter int DEPTH                    = rx_msg_pkg::FIFO_DEPTH
) (
	// Clock, reset, enable
	input  wire logic                          clk_sys,
	input  wire logic                          rst_n,
	input  wire logic                          clkEn,
	// Message from the receive path
	input  wire logic                          msgValid,
	output logic                               msgReady,
	input  wire logic [rx_msg_pkg::KIND_W-1:0] msgKind,
	input  wire logic [15:0]                   msgReqId,
	input  wire logic [15:0]                   msgVendorId,
	input  wire logic                          msgHasData,
	input  wire logic [31:0]                   msgPayload,
	input  wire logic [31:0]                   msgLtr,
	input  wire logic [7:0]                    msgHint,
	// Indication port
	output logic                               indStrobe,
	output logic [rx_msg_pkg::KIND_W-1:0]      indKind,
	output logic [rx_msg_pkg::BYTE_W-1:0]      indData
);
	import rx_msg_pkg::*;

	// Queue memory fill count, zero up to DEPTH
	localparam int OCC_W = $clog2(DEPTH + 1);

	initial begin
		if (DEPTH < 2)
			$error("rx_msg_indication_port DEPTH must be at least 2");
	end

	// ==========================================================================
	// Length and byte order per kind
	// ==========================================================================
	function automatic logic [CNT_W-1:0] kindLen(input logic [KIND_W-1:0] k,
	                                             input logic hasData);
		if (k == KIND_SLOT_PWR || k == KIND_LTR)
			kindLen = LEN_SIX;
		else if (k == KIND_OBFF)
			kindLen = LEN_OBFF;
		else if (k == KIND_VDM0 || k == KIND_VDM1)
			kindLen = hasData ? LEN_VDM_DATA : LEN_VDM_NODATA;
		else if (k <= KIND_PM_NAK || k == KIND_UNLOCK ||
		         (k >= KIND_ATS_FIRST && k <= KIND_ATS_LAST))
			kindLen = LEN_SHORT;
		else
			kindLen = LEN_NONE;                                          // Reserved kinds dropped
	endfunction : kindLen

	wire logic isVdm = (msgKind == KIND_VDM0) || (msgKind == KIND_VDM1);
	wire logic isLtr = (msgKind == KIND_LTR);
	wire logic isObff = (msgKind == KIND_OBFF);

	// Bytes 3..8 of the record; only the first payload doubleword is carried
	wire logic [47:0] tailBytes =
		isVdm  ? {msgPayload, msgVendorId} :
		isLtr  ? {16'h0000, msgLtr} :
		isObff ? {40'h00_0000_0000, msgHint} :
		         {16'h0000, msgPayload};
	wire logic [MAX_BYTES*BYTE_W-1:0] recBytes =
		{tailBytes, msgReqId[7:0], msgReqId[15:8]};                     // bus first
	wire logic [CNT_W-1:0] recLen = kindLen(msgKind, msgHasData);
	wire logic [REC_W-1:0] recIn  = {msgKind, recLen, recBytes};

	// ==========================================================================
	// Queue
	// ==========================================================================
	wire logic             fifoInReady;
	wire logic             fifoOutValid;
	wire logic [REC_W-1:0] fifoOutData;
	logic                  popReady;
	logic                  msgReady_ff;
	logic [OCC_W-1:0]      occ_ff;
	logic [OCC_W-1:0]      nxt_occ;

	// Disabled port or reserved kind: the message is consumed and not queued
	wire logic recUseful = rx_msg_port_enable_param && (recLen != LEN_NONE);
	wire logic msgTake   = msgValid && msgReady_ff;
	wire logic fifoPush  = msgTake && recUseful;
	// Same read condition as inside the queue, for the fill count
	wire logic memPop    = (occ_ff != '0) && (!fifoOutValid || popReady);

	msg_fifo #(
		.WIDTH(REC_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.clkEn   (clkEn),
		.inValid (fifoPush),
		.inReady (fifoInReady),
		.inData  (recIn),
		.outValid(fifoOutValid),
		.outReady(popReady),
		.outData (fifoOutData)
	);

	// ==========================================================================
	// Room tracking
	// ==========================================================================
	// Ready leaves a flop, so the memory fill level is mirrored here and ready
	// is granted only when the coming cycle is sure to have room
	always_comb begin
		nxt_occ = occ_ff;
		if (fifoPush)
			nxt_occ = nxt_occ + OCC_W'(1);
		if (memPop)
			nxt_occ = nxt_occ - OCC_W'(1);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			occ_ff      <= '0;
			msgReady_ff <= 1'b0;
		end else if (clkEn) begin
			occ_ff      <= nxt_occ;
			msgReady_ff <= (nxt_occ < OCC_W'(DEPTH));
		end
	end

	// ==========================================================================
	// Serialiser
	// ==========================================================================
	send_state_t                     state_ff;
	send_state_t                     nxt_state;
	logic [CNT_W-1:0]                cnt_ff;
	logic [CNT_W-1:0]                len_ff;
	logic [MAX_BYTES*BYTE_W-1:0]     shift_ff;
	logic [KIND_W-1:0]               kind_ff;
	logic                            strobe_ff;
	logic [BYTE_W-1:0]               data_ff;
	logic                            gap_ff;

	wire logic [CNT_W-1:0] popLen   = fifoOutData[MAX_BYTES*BYTE_W +: CNT_W];
	wire logic [KIND_W-1:0] popKind = fifoOutData[REC_W-1 -: KIND_W];
	// Idle for two cycles after each message (gap_ff holds the first) gives the mandatory gap
	wire logic canStart  = (state_ff == ST_IDLE) && !gap_ff && fifoOutValid;
	wire logic lastByte  = (state_ff == ST_SEND) && (cnt_ff == len_ff);

	assign popReady = canStart;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (canStart)
					nxt_state = ST_SEND;
			end
			ST_SEND: begin
				if (lastByte)
					nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_ff  <= ST_IDLE;
			cnt_ff    <= '0;
			len_ff    <= '0;
			shift_ff  <= '0;
			kind_ff   <= '0;
			gap_ff    <= 1'b0;
		end else if (clkEn) begin
			state_ff <= nxt_state;
			gap_ff   <= lastByte;
			if (canStart) begin
				len_ff   <= popLen;
				kind_ff  <= popKind;
				shift_ff <= fifoOutData[MAX_BYTES*BYTE_W-1:0];
				cnt_ff   <= 4'h1;
			end else if (state_ff == ST_SEND) begin
				shift_ff <= {{BYTE_W{1'b0}}, shift_ff[MAX_BYTES*BYTE_W-1:BYTE_W]};
				cnt_ff   <= cnt_ff + 4'h1;
			end
		end
	end

	// Output stage: registered copy of the current byte and kind
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strobe_ff   <= 1'b0;
			data_ff     <= '0;
		end else if (clkEn) begin
			strobe_ff   <= (state_ff == ST_SEND);
			data_ff     <= shift_ff[BYTE_W-1:0];
		end
	end

	logic [KIND_W-1:0] indKind_ff;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			indKind_ff <= '0;
		else if (clkEn)
			indKind_ff <= kind_ff;
	end

	// The source must hold valid until it sees ready high
	assign msgReady  = msgReady_ff;
	assign indStrobe = strobe_ff;
	assign indKind   = indKind_ff;
	assign indData   = data_ff;

	// ==========================================================================
	// Checks
	// ==========================================================================
	// Strobe run length counted on the output itself
	logic [CNT_W-1:0] runCnt_ff;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			runCnt_ff <= '0;
		else if (clkEn)
			runCnt_ff <= indStrobe ? runCnt_ff + 4'h1 : '0;
	end

	// A merged indication would run past its length
	property p_gap;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && indStrobe && (runCnt_ff + 4'h1 == len_ff)) |=> !indStrobe;
	endproperty
	a_gap: assert property (p_gap) else $error("strobe gap missing");

	property p_len_reach;
		@(posedge clk_sys) disable iff (!rst_n)
		(indStrobe && (runCnt_ff + 4'h1 < len_ff)) |=> indStrobe;
	endproperty
	a_len_reach: assert property (p_len_reach) else $error("strobe ended early");

	property p_disabled;
		@(posedge clk_sys) disable iff (!rst_n)
		!rx_msg_port_enable_param |-> !indStrobe;
	endproperty
	a_disabled: assert property (p_disabled) else $error("strobe while disabled");

	property p_max_len;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && $rose(indStrobe)) |-> ##[1:8] !indStrobe;
	endproperty
	a_max_len: assert property (p_max_len) else $error("strobe too long");

	property p_short;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(indStrobe) && (indKind <= KIND_PM_NAK) && clkEn) |->
			##1 indStrobe ##1 !indStrobe;
	endproperty
	a_short: assert property (p_short) else $error("short message not 2 cycles");

	property p_obff;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(indStrobe) && indKind == KIND_OBFF && clkEn) |->
			##1 indStrobe ##1 indStrobe ##1 !indStrobe;
	endproperty
	a_obff: assert property (p_obff) else $error("hint message too short");

	property p_kind_stable;
		@(posedge clk_sys) disable iff (!rst_n)
		($past(indStrobe) && indStrobe) |-> $stable(indKind);
	endproperty
	a_kind_stable: assert property (p_kind_stable) else $error("kind changed in strobe");

	property p_no_reserved;
		@(posedge clk_sys) disable iff (!rst_n)
		indStrobe |-> (indKind <= KIND_ATS_LAST);
	endproperty
	a_no_reserved: assert property (p_no_reserved) else $error("reserved kind shown");

	property p_start_from_queue;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && canStart) |=> ##1 (indStrobe && (indKind == $past(popKind, 2)));
	endproperty
	a_start_from_queue: assert property (p_start_from_queue) else $error("start lost");

	property p_first_byte;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && canStart) |=> ##1 (indData == $past(fifoOutData[BYTE_W-1:0], 2));
	endproperty
	a_first_byte: assert property (p_first_byte) else $error("bus number not first");

	property p_second_byte;
		@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && canStart) |=> ##2 (indData == $past(fifoOutData[2*BYTE_W-1:BYTE_W], 3));
	endproperty
	a_second_byte: assert property (p_second_byte) else $error("devfn not second");

	property p_room;
		@(posedge clk_sys) disable iff (!rst_n)
		fifoPush |-> fifoInReady;
	endproperty
	a_room: assert property (p_room) else $error("message taken into full queue");

	property p_reset_quiet;
		@(posedge clk_sys)
		!rst_n |-> (!indStrobe && !msgReady);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("activity in reset");

	property p_len_legal;
		@(posedge clk_sys) disable iff (!rst_n)
		indStrobe |-> (len_ff == LEN_SHORT || len_ff == LEN_OBFF || len_ff == LEN_SIX ||
			len_ff == LEN_VDM_NODATA || len_ff == LEN_VDM_DATA);
	endproperty
	a_len_legal: assert property (p_len_legal) else $error("illegal strobe length");

	property p_slot_len;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(indStrobe) && indKind == KIND_SLOT_PWR) |-> (len_ff == LEN_SIX);
	endproperty
	a_slot_len: assert property (p_slot_len) else $error("slot power not six cycles");

	property p_ltr_len;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(indStrobe) && indKind == KIND_LTR) |-> (len_ff == LEN_SIX);
	endproperty
	a_ltr_len: assert property (p_ltr_len) else $error("latency not six cycles");

	property p_vdm_len;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(indStrobe) && (indKind == KIND_VDM0 || indKind == KIND_VDM1)) |->
			(len_ff == LEN_VDM_NODATA || len_ff == LEN_VDM_DATA);
	endproperty
	a_vdm_len: assert property (p_vdm_len) else $error("vendor length wrong");

	property p_rest_short;
		@(posedge clk_sys) disable iff (!rst_n)
		($rose(indStrobe) && (indKind == KIND_UNLOCK ||
			(indKind >= KIND_ATS_FIRST && indKind <= KIND_ATS_LAST))) |-> (len_ff == LEN_SHORT);
	endproperty
	a_rest_short: assert property (p_rest_short) else $error("unlock or ATS not 2 cycles");

	property p_one_hot;
		@(posedge clk_sys) disable iff (!rst_n)
		$onehot(state_ff);
	endproperty
	a_one_hot: assert property (p_one_hot) else $error("serialiser state not one-hot");

	property p_off_no_push;
		@(posedge clk_sys) disable iff (!rst_n)
		!rx_msg_port_enable_param |-> !fifoPush;
	endproperty
	a_off_no_push: assert property (p_off_no_push) else $error("queued while disabled");

	property p_vdm_dword;
		@(posedge clk_sys) disable iff (!rst_n)
		indStrobe |-> (runCnt_ff < LEN_VDM_DATA);
	endproperty
	a_vdm_dword: assert property (p_vdm_dword) else $error("more than one dword shown");
endmodule : rx_msg_indication_port

// ==== verif/msg_sink.sv ====
// Model of the user logic that takes every message indication
`timescale 1ns/1ps
module msg_sink (
	// Clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          rst_n,
	// Indication port
	input  wire logic                          indStrobe,
	input  wire logic [rx_msg_pkg::KIND_W-1:0] indKind,
	input  wire logic [rx_msg_pkg::BYTE_W-1:0] indData,
	// Collected message: kind, length, bytes
	output logic                               gotMsg,
	output logic [72:0]                        gotRec
);
	import rx_msg_pkg::*;
	logic        prev_ff;
	logic [3:0]  cnt_ff;
	logic [4:0]  kind_ff;
	logic [63:0] bytes_ff;
	// ==========================================================
	// Capture
	// No stall path: every strobe cycle is taken as it comes
	// Issues no requests, so no completions can pile up
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff <= 1'b0;
			gotMsg  <= 1'b0;
			cnt_ff  <= 4'h0;
		end else begin
			prev_ff <= indStrobe;
			// Strobes without a gap merge and show up as a wrong length
			gotMsg  <= prev_ff & ~indStrobe;
			if (indStrobe && !prev_ff) begin
				kind_ff  <= indKind;
				bytes_ff <= {56'h0, indData};
				cnt_ff   <= 4'h1;
			end else if (indStrobe) begin
				bytes_ff[{cnt_ff, 3'b000} +: 8] <= indData;
				cnt_ff <= cnt_ff + 4'h1;
				// Kind drifting mid-strobe is marked with a reserved code
				if (indKind !== kind_ff) kind_ff <= 5'h1F;
			end
		end
	end
	assign gotRec = {kind_ff, cnt_ff, bytes_ff};
endmodule : msg_sink

// ==== verif/rx_msg_indication_port_bench.sv ====
// Self-checking bench for the receive message indication port
`timescale 1ns/1ps
module rx_msg_indication_port_bench;
	import rx_msg_pkg::*;
	typedef struct packed {
		logic [4:0]  k;
		logic [3:0]  n;
		logic [63:0] b;
	} exp_t;
	logic        clk_sys     = 1'b0;
	logic        rst_n       = 1'b0;
	logic        clkEn       = 1'b1;
	logic        msgValid    = 1'b0;
	logic [4:0]  msgKind     = 5'h00;
	logic [15:0] msgReqId    = 16'h0000;
	logic [15:0] msgVendorId = 16'h0000;
	logic        msgHasData  = 1'b0;
	logic [31:0] msgPayload  = 32'h0;
	logic [31:0] msgLtr      = 32'h0;
	logic [7:0]  msgHint     = 8'h00;
	wire         msgReady, offReady, indStrobe, offStrobe, gotMsg;
	wire  [4:0]  indKind;
	wire  [7:0]  indData;
	wire  [72:0] gotRec;
	exp_t        expQ[$];
	int          miscompares = 0;
	int          checks      = 0;
	int          refused     = 0;
	int          offSeen     = 0;
	integer      seed        = 47906;

	initial forever #12.5 clk_sys = ~clk_sys;

	rx_msg_indication_port dut_u (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.clkEn      (clkEn),
		.msgValid   (msgValid),
		.msgReady   (msgReady),
		.msgKind    (msgKind),
		.msgReqId   (msgReqId),
		.msgVendorId(msgVendorId),
		.msgHasData (msgHasData),
		.msgPayload (msgPayload),
		.msgLtr     (msgLtr),
		.msgHint    (msgHint),
		.indStrobe  (indStrobe),
		.indKind    (indKind),
		.indData    (indData)
	);
	rx_msg_indication_port #(
		.rx_msg_port_enable_param(1'b0)
	) off_u (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.clkEn      (clkEn),
		.msgValid   (msgValid),
		.msgReady   (offReady),
		.msgKind    (msgKind),
		.msgReqId   (msgReqId),
		.msgVendorId(msgVendorId),
		.msgHasData (msgHasData),
		.msgPayload (msgPayload),
		.msgLtr     (msgLtr),
		.msgHint    (msgHint),
		.indStrobe  (offStrobe),
		.indKind    (),
		.indData    ()
	);
	msg_sink sink_u (.clk_sys(clk_sys), .rst_n(rst_n), .indStrobe(indStrobe),
		.indKind(indKind), .indData(indData), .gotMsg(gotMsg), .gotRec(gotRec));

	// ==========================================================
	// Checking
	task automatic chk(input string what, input logic [72:0] exp, input logic [72:0] got);
		checks++;
		if (exp !== got) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	always @(negedge clk_sys) begin
		if (gotMsg === 1'b1) begin
			if (expQ.size() == 0) chk("unexpected message", '1, gotRec);
			else chk("message", expQ.pop_front(), gotRec);
		end
		if (rst_n && offStrobe !== 1'b0) offSeen++;
		// Disabled port still consumes every message
		if (msgValid === 1'b1 && offReady !== 1'b1) offSeen++;
	end

	// ==========================================================
	// Stimulus
	// Holds valid across back-to-back takes; expectation noted at the take edge
	task automatic send(input logic [4:0] k);
		exp_t x;
		logic vdm;
		int   w;
		@(negedge clk_sys);
		msgKind     = k;
		msgReqId    = 16'($random(seed));
		msgVendorId = 16'($random(seed));
		msgHasData  = 1'($random(seed));
		msgPayload  = $random(seed);
		msgLtr      = $random(seed);
		msgHint     = 8'($random(seed));
		msgValid    = 1'b1;
		vdm         = (k == KIND_VDM0) || (k == KIND_VDM1);
		x.k         = k;
		x.b         = {48'h0, msgReqId[7:0], msgReqId[15:8]};
		if (k == KIND_SLOT_PWR) x.b[47:16] = msgPayload;
		if (k == KIND_LTR) x.b[47:16] = msgLtr;
		if (k == KIND_OBFF) x.b[23:16] = msgHint;
		if (vdm) x.b[31:16] = msgVendorId;
		if (vdm && msgHasData) x.b[63:32] = msgPayload;
		x.n = (k == KIND_SLOT_PWR || k == KIND_LTR) ? LEN_SIX :
			(k == KIND_OBFF) ? LEN_OBFF :
			vdm ? (msgHasData ? LEN_VDM_DATA : LEN_VDM_NODATA) : LEN_SHORT;
		for (w = 0; w < 50 && msgReady !== 1'b1; w++) begin
			refused++;
			@(negedge clk_sys);
		end
		if (msgReady !== 1'b1) begin
			miscompares++;
			$display("[ERR] msgReady expected 1 seen %b", msgReady);
			return;
		end
		@(posedge clk_sys);
		if (k < 5'h19) expQ.push_back(x);
	endtask : send

	initial begin
		repeat (4) @(posedge clk_sys);
		chk("strobe in reset", 73'h0, {72'h0, indStrobe});
		@(negedge clk_sys);
		rst_n = 1'b1;
		repeat (2) @(negedge clk_sys);
		// Every code once, then a random mix; queue fills while strobes drain
		for (int i = 0; i < 72; i++) send(i < 32 ? i[4:0] : 5'($random(seed)));
		@(negedge clk_sys);
		msgValid = 1'b0;
		chk("queue refused when full", 73'h1, {72'h0, refused > 0});
		$display("test all kinds and queue fill done");
		for (int i = 0; i < 400 && (expQ.size() != 0 || indStrobe !== 1'b0); i++) begin
			@(negedge clk_sys);
		end
		chk("all indications seen", 73'h0, 73'(expQ.size()));
		chk("disabled port strobe or stall", 73'h0, 73'(offSeen));
		$display("test drain and disabled port done");
		end_sim;
	end

	// Run needs under 1500 cycles; twice that means a hang
	initial begin
		#75000;
		miscompares++;
		$display("[ERR] watchdog expected finish seen timeout");
		end_sim;
	end
endmodule : rx_msg_indication_port_bench
